/* File: core/serial_reference_exchange.sv */
// reference exchange over the first serial port: master/slave chain of one signed value
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - role follows the port role setting
// - master sends on its own, still receives
// - slave waits, replies at once on reception
// - received value times signed ratio, default one
// - optional negation of received value
// - received value shown on monitor, both roles
// - outgoing value shown on monitor before sending
// - outgoing value from selected source, 400 disconnected
// - same source value sent in both roles
// - processed value written to chosen destination
// - two units: master uses slave as function
module serial_reference_exchange
	import ref_exchange_pkg::*;
#(
	parameter int unsigned PERIOD_CYCLES = EXCH_PERIOD_CYCLES,
	parameter int unsigned GAP_LIMIT = GAP_CYCLES
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire exchange_cfg_t cfg,
	input wire logic link_rx,
	output logic link_tx,
	output logic [SEL_W-1:0] source_index,
	input wire logic signed [VALUE_W-1:0] source_value,
	output dest_write_t dest,
	output logic signed [VALUE_W-1:0] receive_value_monitor,
	output logic signed [VALUE_W-1:0] transmit_value_monitor,
	input wire logic error_clear,
	output logic error_flag,
	output logic tx_busy
);

	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01} tx_state_t;

	// ----------------------------------------------------------------
	// configuration hold and receive pin synchroniser
	// ----------------------------------------------------------------
	exchange_cfg_t cfg_q;
	logic rx_meta, rx_sync;
	rx_char_t rx_char;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= CFG_RESET;
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			cfg_q <= cfg;
			rx_meta <= link_rx;
			rx_sync <= rx_meta;
		end
	end

	serial_char_rx u_rx (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.rx_level(rx_sync),
		.rx_char(rx_char)
	);

	// ----------------------------------------------------------------
	// frame assembly: low byte, high byte, check byte
	// ----------------------------------------------------------------
	logic [1:0] char_idx, next_char_idx;
	logic [7:0] low_byte, next_low_byte;
	logic [7:0] high_byte, next_high_byte;
	logic [PERIOD_W-1:0] gap_cnt, next_gap_cnt;
	logic rx_done, next_rx_done;
	logic signed [VALUE_W-1:0] rx_word, next_rx_word;
	logic rx_bad;

	always_comb begin
		next_char_idx = char_idx;
		next_low_byte = low_byte;
		next_high_byte = high_byte;
		next_gap_cnt = '0;
		next_rx_done = 1'b0;
		next_rx_word = rx_word;
		rx_bad = 1'b0;
		if (rx_char.frame_err) begin
			next_char_idx = '0;
			rx_bad = 1'b1;
		end else if (rx_char.valid) begin
			case (char_idx)
				2'h0: begin
					next_low_byte = rx_char.data;
					next_char_idx = 2'h1;
				end
				2'h1: begin
					next_high_byte = rx_char.data;
					next_char_idx = 2'h2;
				end
				default: begin
					next_char_idx = '0;
					if (rx_char.data == (low_byte ^ high_byte ^ CHECK_SEED)) begin
						next_rx_word = {high_byte, low_byte};
						next_rx_done = 1'b1;
					end else begin
						rx_bad = 1'b1;
					end
				end
			endcase
		end else if (char_idx != 2'h0) begin
			next_gap_cnt = gap_cnt + 1'b1;
			// a frame that stalls between characters is thrown away
			if (gap_cnt == PERIOD_W'(GAP_LIMIT - 1)) begin
				next_char_idx = '0;
				next_gap_cnt = '0;
				rx_bad = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			char_idx <= '0;
			low_byte <= '0;
			high_byte <= '0;
			gap_cnt <= '0;
			rx_done <= 1'b0;
			rx_word <= '0;
		end else begin
			char_idx <= next_char_idx;
			low_byte <= next_low_byte;
			high_byte <= next_high_byte;
			gap_cnt <= next_gap_cnt;
			rx_done <= next_rx_done;
			rx_word <= next_rx_word;
		end
	end

	// ----------------------------------------------------------------
	// receive processing: sign, ratio, limit, monitor, destination
	// ----------------------------------------------------------------
	logic signed [VALUE_W:0] signed_in;
	logic signed [2*VALUE_W+1:0] product, next_product;
	logic signed [2*VALUE_W+1:0] quotient;
	logic prod_valid, next_prod_valid;
	logic signed [VALUE_W-1:0] next_rx_mon;
	dest_write_t next_dest;

	always_comb begin
		signed_in = (cfg_q.receive_polarity == POL_INVERT) ? -{rx_word[VALUE_W-1], rx_word}
			: {rx_word[VALUE_W-1], rx_word};
		next_product = product;
		next_prod_valid = rx_done;
		if (rx_done) begin
			next_product = signed_in * cfg_q.receive_scale_factor;
		end
		quotient = product / (2*VALUE_W+2)'(SCALE_ONE);
		next_rx_mon = receive_value_monitor;
		next_dest = '{index: cfg_q.receive_destination_select, value: dest.value, write: 1'b0};
		if (prod_valid) begin
			// hold the monitor inside its +/-300.00 % span
			if (quotient > (2*VALUE_W+2)'(VALUE_LIMIT)) begin
				next_rx_mon = VALUE_LIMIT;
			end else if (quotient < -(2*VALUE_W+2)'(VALUE_LIMIT)) begin
				next_rx_mon = -VALUE_LIMIT;
			end else begin
				next_rx_mon = quotient[VALUE_W-1:0];
			end
			next_dest.value = next_rx_mon;
			next_dest.write = (cfg_q.receive_destination_select != SEL_DISCONNECT)
				&& (cfg_q.receive_destination_select <= SEL_MAX);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			product <= '0;
			prod_valid <= 1'b0;
			receive_value_monitor <= '0;
			dest <= '{index: SEL_DISCONNECT, value: '0, write: 1'b0};
		end else begin
			product <= next_product;
			prod_valid <= next_prod_valid;
			receive_value_monitor <= next_rx_mon;
			dest <= next_dest;
		end
	end

	// ----------------------------------------------------------------
	// error flag: hardware set wins over clear
	// ----------------------------------------------------------------
	logic next_error_flag;

	always_comb begin
		next_error_flag = error_flag;
		if (error_clear) begin
			next_error_flag = 1'b0;
		end
		if (rx_bad) begin
			next_error_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			error_flag <= 1'b0;
		end else begin
			error_flag <= next_error_flag;
		end
	end

	// ----------------------------------------------------------------
	// transmit trigger: master period or slave reception
	// ----------------------------------------------------------------
	logic [PERIOD_W-1:0] period_cnt, next_period_cnt;
	logic period_tick;
	logic tx_request;
	logic pending, next_pending;

	always_comb begin
		next_period_cnt = '0;
		period_tick = 1'b0;
		if (cfg_q.port_role_select == ROLE_MASTER) begin
			next_period_cnt = period_cnt + 1'b1;
			if (period_cnt == PERIOD_W'(PERIOD_CYCLES - 1)) begin
				next_period_cnt = '0;
				period_tick = 1'b1;
			end
		end
		tx_request = (cfg_q.port_role_select == ROLE_MASTER) ? period_tick
			: rx_done;
	end

	// ----------------------------------------------------------------
	// transmit shifter: three characters, LSB first, idle high
	// ----------------------------------------------------------------
	tx_state_t tx_state, next_tx_state;
	logic [FRAME_BITS-1:0] tx_shift, next_tx_shift;
	logic [4:0] tx_bits, next_tx_bits;
	logic [CNT_W-1:0] tx_cnt, next_tx_cnt;
	logic signed [VALUE_W-1:0] tx_value;
	logic signed [VALUE_W-1:0] next_tx_mon;
	logic [7:0] tx_check;
	logic next_link_tx;

	always_comb begin
		// disconnected or out-of-range source sends zero
		if (cfg_q.transmit_source_select == SEL_DISCONNECT
			|| cfg_q.transmit_source_select > SEL_MAX) begin
			tx_value = '0;
		end else if (source_value > VALUE_LIMIT) begin
			tx_value = VALUE_LIMIT;
		end else if (source_value < -VALUE_LIMIT) begin
			tx_value = -VALUE_LIMIT;
		end else begin
			tx_value = source_value;
		end
		tx_check = tx_value[7:0] ^ tx_value[15:8] ^ CHECK_SEED;
		next_tx_state = tx_state;
		next_tx_shift = tx_shift;
		next_tx_bits = tx_bits;
		next_tx_cnt = tx_cnt;
		next_tx_mon = transmit_value_monitor;
		next_link_tx = link_tx;
		next_pending = pending;
		if (tx_request) begin
			next_pending = 1'b1;
		end
		case (tx_state)
			TX_IDLE: begin
				next_link_tx = 1'b1;
				if (pending) begin
					next_pending = tx_request;
					next_tx_mon = tx_value;
					next_tx_shift = {1'b1, tx_check, 1'b0, 1'b1, tx_value[15:8], 1'b0,
						1'b1, tx_value[7:0], 1'b0};
					next_tx_bits = '0;
					next_tx_cnt = '0;
					next_tx_state = TX_SEND;
				end
			end
			TX_SEND: begin
				next_link_tx = tx_shift[0];
				next_tx_cnt = tx_cnt + 1'b1;
				if (tx_cnt == CNT_W'(BIT_CYCLES - 1)) begin
					next_tx_cnt = '0;
					next_tx_shift = {1'b1, tx_shift[FRAME_BITS-1:1]};
					next_tx_bits = tx_bits + 1'b1;
					if (tx_bits == 5'(FRAME_BITS - 1)) begin
						next_tx_state = TX_IDLE;
					end
				end
			end
			default: begin
				next_tx_state = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			period_cnt <= '0;
			pending <= 1'b0;
			tx_state <= TX_IDLE;
			tx_shift <= '1;
			tx_bits <= '0;
			tx_cnt <= '0;
			transmit_value_monitor <= '0;
			link_tx <= 1'b1;
		end else begin
			period_cnt <= next_period_cnt;
			pending <= next_pending;
			tx_state <= next_tx_state;
			tx_shift <= next_tx_shift;
			tx_bits <= next_tx_bits;
			tx_cnt <= next_tx_cnt;
			transmit_value_monitor <= next_tx_mon;
			link_tx <= next_link_tx;
		end
	end

	assign source_index = cfg_q.transmit_source_select;
	assign tx_busy = (tx_state != TX_IDLE) || pending;

endmodule
`default_nettype wire

/* File: include/ref_exchange_pkg.sv */
// constants, enumerations and carriers shared by the reference exchange block
package ref_exchange_pkg;

	// ----------------------------------------------------------------
	// clock and link timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned LINK_BAUD = 115_200;
	localparam int unsigned BIT_CYCLES = CLK_HZ / LINK_BAUD;
	localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
	localparam int unsigned BITS_PER_CHAR = 10;
	localparam int unsigned CHARS_PER_FRAME = 3;
	localparam int unsigned FRAME_BITS = BITS_PER_CHAR * CHARS_PER_FRAME;
	localparam int unsigned EXCH_PERIOD_US = 5000;
	localparam int unsigned EXCH_PERIOD_CYCLES = (CLK_HZ / 1_000_000) * EXCH_PERIOD_US;
	localparam int unsigned GAP_CHARS = 3;
	localparam int unsigned GAP_CYCLES = BIT_CYCLES * BITS_PER_CHAR * GAP_CHARS;
	localparam int unsigned CNT_W = 11;
	localparam int unsigned PERIOD_W = 24;

	// ----------------------------------------------------------------
	// value formats (100.00 % = 10000 counts, ratio 1.0000 = 10000)
	// ----------------------------------------------------------------
	localparam int unsigned VALUE_W = 16;
	localparam int unsigned SEL_W = 10;
	localparam logic [SEL_W-1:0] SEL_MAX = 10'h2D0;
	localparam logic [SEL_W-1:0] SEL_DISCONNECT = 10'h190;
	localparam logic signed [VALUE_W-1:0] SCALE_ONE = 16'sh2710;
	localparam logic signed [VALUE_W-1:0] SCALE_DEFAULT = 16'sh2710;
	localparam logic signed [VALUE_W-1:0] VALUE_LIMIT = 16'sh7530;
	localparam logic [7:0] CHECK_SEED = 8'hA5;

	// ----------------------------------------------------------------
	// enumerations and carriers
	// ----------------------------------------------------------------
	typedef enum logic {ROLE_MASTER = 1'b0, ROLE_SLAVE = 1'b1} port_role_t;
	typedef enum logic {POL_NON_INVERT = 1'b0, POL_INVERT = 1'b1} polarity_t;

	typedef struct packed {
		port_role_t port_role_select;
		logic signed [VALUE_W-1:0] receive_scale_factor;
		polarity_t receive_polarity;
		logic [SEL_W-1:0] transmit_source_select;
		logic [SEL_W-1:0] receive_destination_select;
	} exchange_cfg_t;

	localparam exchange_cfg_t CFG_RESET = '{ROLE_MASTER, SCALE_DEFAULT, POL_NON_INVERT,
		SEL_DISCONNECT, SEL_DISCONNECT};

	typedef struct packed {
		logic [7:0] data;
		logic valid;
		logic frame_err;
	} rx_char_t;

	typedef struct packed {
		logic [SEL_W-1:0] index;
		logic signed [VALUE_W-1:0] value;
		logic write;
	} dest_write_t;

endpackage

/* File: core/serial_char_rx.sv */
// one-character asynchronous receiver for the exchange link
`timescale 1ns/1ns
`default_nettype none
module serial_char_rx
	import ref_exchange_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic rx_level,
	output rx_char_t rx_char
);

	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
		RX_STOP = 2'b10} rx_state_t;

	rx_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [2:0] bit_idx, next_bit_idx;
	logic [7:0] shift, next_shift;
	rx_char_t next_rx_char;

	// ----------------------------------------------------------------
	// start detect, mid-bit sampling, stop check
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bit_idx = bit_idx;
		next_shift = shift;
		next_rx_char = '{data: shift, valid: 1'b0, frame_err: 1'b0};
		case (state)
			RX_IDLE: begin
				next_cnt = '0;
				if (!rx_level) begin
					next_state = RX_START;
				end
			end
			RX_START: begin
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(HALF_BIT_CYCLES)) begin
					next_cnt = '0;
					next_bit_idx = '0;
					// a glitch shorter than half a bit is not a start
					next_state = rx_level ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(BIT_CYCLES - 1)) begin
					next_cnt = '0;
					next_shift = {rx_level, shift[7:1]};
					next_bit_idx = bit_idx + 1'b1;
					if (bit_idx == 3'h7) begin
						next_state = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(BIT_CYCLES - 1)) begin
					next_cnt = '0;
					next_state = RX_IDLE;
					next_rx_char.valid = rx_level;
					next_rx_char.frame_err = !rx_level;
				end
			end
			default: begin
				next_state = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= RX_IDLE;
			cnt <= '0;
			bit_idx <= '0;
			shift <= '0;
			rx_char <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bit_idx <= next_bit_idx;
			shift <= next_shift;
			rx_char <= next_rx_char;
		end
	end

endmodule
`default_nettype wire

/* File: test/ref_peer_model.sv */
// far-side drive model: sends frames to the block and decodes its frames
`timescale 1ns/1ns
`default_nettype none
module ref_peer_model
	import ref_exchange_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rx_line,
	output logic tx_line,
	output logic signed [VALUE_W-1:0] rx_value,
	output int rx_count
);
	initial begin
		tx_line = 1'b1;
		rx_value = '0;
		rx_count = 0;
	end

	// one character: start, eight data bits lsb first, stop
	task automatic send_char(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int k = 0; k < 10; k++) begin
			tx_line <= f[k];
			repeat (BIT_CYCLES) @(posedge clk_sys);
		end
	endtask

	// our transmit line feeds the next unit's receive line
	task automatic send_frame(input logic signed [VALUE_W-1:0] v, input logic bad);
		send_char(v[7:0]);
		send_char(v[15:8]);
		send_char(v[7:0] ^ v[15:8] ^ CHECK_SEED ^ {7'h00, bad});
	endtask

	// decode frames from the block, sampling mid-bit
	always begin
		logic [7:0] b [3];
		for (int k = 0; k < 3; k++) begin
			@(negedge rx_line);
			repeat (HALF_BIT_CYCLES) @(posedge clk_sys);
			for (int j = 0; j < 8; j++) begin
				repeat (BIT_CYCLES) @(posedge clk_sys);
				b[k][j] = rx_line;
			end
			repeat (BIT_CYCLES) @(posedge clk_sys);
		end
		if ((b[0] ^ b[1] ^ CHECK_SEED) == b[2]) begin
			rx_value = {b[1], b[0]};
			rx_count++;
		end
	end
endmodule
`default_nettype wire

/* File: test/serial_reference_exchange_sva.sv */
// port assertions for the reference exchange block
`timescale 1ns/1ns
`default_nettype none
module serial_reference_exchange_sva
	import ref_exchange_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire exchange_cfg_t cfg,
	input wire logic link_rx,
	input wire logic link_tx,
	input wire logic [SEL_W-1:0] source_index,
	input wire logic signed [VALUE_W-1:0] source_value,
	input wire dest_write_t dest,
	input wire logic signed [VALUE_W-1:0] receive_value_monitor,
	input wire logic signed [VALUE_W-1:0] transmit_value_monitor,
	input wire logic error_clear,
	input wire logic error_flag,
	input wire logic tx_busy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_write_pulse: assert property (dest.write |=> !dest.write)
		else $error("destination write longer than one cycle");
	a_write_monitor: assert property (dest.write |-> dest.value == receive_value_monitor)
		else $error("destination value differs from monitor");
	a_dest_index: assert property (dest.write |-> dest.index != SEL_DISCONNECT
		&& dest.index <= SEL_MAX)
		else $error("write to a disconnected destination");
	a_rx_range: assert property (receive_value_monitor <= VALUE_LIMIT
		&& receive_value_monitor >= -VALUE_LIMIT)
		else $error("receive monitor out of range");
	a_tx_range: assert property (transmit_value_monitor <= VALUE_LIMIT
		&& transmit_value_monitor >= -VALUE_LIMIT)
		else $error("transmit monitor out of range");
	a_source_follow: assert property ($past(arst_n)
		|-> source_index == $past(cfg.transmit_source_select))
		else $error("source index does not follow selector");
	a_idle_high: assert property (!tx_busy |-> link_tx)
		else $error("transmit line low while idle");
	a_slave_reply: assert property (dest.write && cfg.port_role_select == ROLE_SLAVE
		&& !$past(tx_busy, 3) |=> !link_tx)
		else $error("slave did not reply at once");
	a_error_sticky: assert property (error_flag && !error_clear |=> error_flag)
		else $error("error flag dropped without clear");

	c_dest_write: cover property (dest.write);
	c_error: cover property ($rose(error_flag));
	c_slave_send: cover property (cfg.port_role_select == ROLE_SLAVE && $fell(link_tx));
endmodule

bind serial_reference_exchange serial_reference_exchange_sva i_sva (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.cfg(cfg),
	.link_rx(link_rx),
	.link_tx(link_tx),
	.source_index(source_index),
	.source_value(source_value),
	.dest(dest),
	.receive_value_monitor(receive_value_monitor),
	.transmit_value_monitor(transmit_value_monitor),
	.error_clear(error_clear),
	.error_flag(error_flag),
	.tx_busy(tx_busy)
);
`default_nettype wire

/* File: test/tb_serial_reference_exchange.sv */
// self-checking bench: master and slave exchanges against the peer model
`timescale 1ns/1ns
`default_nettype none
module tb_serial_reference_exchange import ref_exchange_pkg::*;;
	logic clk_sys, arst_n, link_rx, link_tx, error_clear, error_flag, tx_busy, quiet;
	exchange_cfg_t cfg;
	dest_write_t dest;
	logic [SEL_W-1:0] source_index, w_idx;
	logic signed [VALUE_W-1:0] source_value, receive_value_monitor, transmit_value_monitor;
	logic signed [VALUE_W-1:0] rv, ex, peer_value, w_val;
	int failures, samples_checked, n_writes, tx_falls, peer_count;

	serial_reference_exchange #(.PERIOD_CYCLES(33000), .GAP_LIMIT(11000)) i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .cfg(cfg), .link_rx(link_rx), .link_tx(link_tx),
		.source_index(source_index), .source_value(source_value), .dest(dest),
		.receive_value_monitor(receive_value_monitor),
		.transmit_value_monitor(transmit_value_monitor),
		.error_clear(error_clear), .error_flag(error_flag), .tx_busy(tx_busy));
	ref_peer_model i_peer (.clk_sys(clk_sys), .rx_line(link_tx), .tx_line(link_rx),
		.rx_value(peer_value), .rx_count(peer_count));

	// ----------------------------------------------------------------
	// clock, observers, helpers
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (dest.write === 1'b1) begin
		n_writes++;
		w_idx <= dest.index;
		w_val <= dest.value;
	end
	// low samples of the transmit line while the slave must stay quiet
	always @(posedge clk_sys) if (quiet && link_tx === 1'b0) tx_falls++;

	// expected received value: sign, ratio, truncate, clamp
	function automatic logic signed [VALUE_W-1:0] f_scale(input int x, input int s, input logic inv);
		int v;
		v = inv ? -x : x;
		v = v * s / 10000;
		if (v > 30000) v = 30000;
		if (v < -30000) v = -30000;
		return VALUE_W'(v);
	endfunction
	task automatic check(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1) begin
			failures++;
			$display("Error %0t %s", $time, what);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		// three frames of link time plus slack for reset and processing
		repeat (3 * FRAME_BITS * BIT_CYCLES + 2000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(60492));
		{failures, samples_checked, n_writes, tx_falls, quiet} = '0;
		arst_n = 1'b0;
		error_clear = 1'b0;
		rv = VALUE_W'(int'($urandom_range(60000)) - 30000);
		cfg = '{ROLE_MASTER, VALUE_W'(int'($urandom_range(60000)) - 30000),
			polarity_t'($urandom_range(1)), SEL_W'($urandom_range(399)),
			SEL_W'(401 + $urandom_range(319))};
		source_value = VALUE_W'(int'($urandom_range(60000)) - 30000);
		repeat (3) @(posedge clk_sys);
		check(link_tx === 1'b1 && error_flag === 1'b0 && tx_busy === 1'b0, "reset outputs");
		check(dest.write === 1'b0 && receive_value_monitor === '0, "reset receive side");
		check(source_index === SEL_DISCONNECT && transmit_value_monitor === '0, "reset source");
		@(posedge clk_sys);
		arst_n <= 1'b1;
		// master receives a random frame before its own first send
		i_peer.send_frame(rv, 1'b0);
		ex = f_scale(rv, cfg.receive_scale_factor, cfg.receive_polarity);
		check(receive_value_monitor === ex, "master receive monitor");
		check(n_writes == 1 && w_idx === cfg.receive_destination_select, "dest index");
		check(w_val === ex, "dest value");
		check(source_index === cfg.transmit_source_select, "source index");
		// corrupted check byte while the master sends
		i_peer.send_frame(rv ^ 16'h0101, 1'b1);
		check(error_flag === 1'b1 && receive_value_monitor === ex, "bad frame kept");
		for (int k = 0; k < 20000 && peer_count == 0; k++) @(posedge clk_sys);
		check(peer_count == 1 && peer_value === source_value, "master frame");
		check(transmit_value_monitor === source_value, "transmit monitor");
		error_clear <= 1'b1;
		@(posedge clk_sys);
		error_clear <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check(error_flag === 1'b0, "error clear");
		// slave: stays quiet, then replies at once; clamp corner
		cfg.port_role_select <= ROLE_SLAVE;
		cfg.receive_scale_factor <= -16'sh7530;
		cfg.receive_polarity <= polarity_t'(!cfg.receive_polarity);
		source_value <= VALUE_W'(int'($urandom_range(60000)) - 30000);
		quiet <= 1'b1;
		@(posedge clk_sys);
		fork
			i_peer.send_frame(VALUE_LIMIT, 1'b0);
		join_none
		for (int k = 0; k < 40000 && dest.write !== 1'b1; k++) @(posedge clk_sys);
		quiet <= 1'b0;
		check(tx_falls == 0 && peer_count == 1, "slave quiet");
		// start bit stands one cycle after the destination write
		@(posedge clk_sys);
		check(link_tx === 1'b0, "slave reply start");
		check(receive_value_monitor === f_scale(30000, -30000, cfg.receive_polarity), "clamp");
		check(transmit_value_monitor === source_value, "slave sends source");
		conclude();
	end
endmodule
`default_nettype wire
